// ===== design/cbstc_top.sv
// Buffer flags, pair control, transmit pick and header decode for a CAN node.
// Assumes AHB-Lite master in the hclk domain and a CAN core driving the events.
//
// Contract
// - Extended mask bit 1 compares that identifier bit, 0 makes it don't-care.
// - Thirty-two receive full flags in two registers, set when a message is stored.
// - Full and overflow flags readable; writing 0 clears, writing 1 changes nothing.
// - Storing into a buffer whose full flag is set sets its overflow flag.
// - Pair control: low byte is even buffer, high byte odd, same fields.
// - Bit 7 set makes the buffer transmit, clear makes it receive.
// - Abort status reads 1 after abort, 0 after successful transmission.
// - Arbitration lost status set when the message loses arbitration.
// - Transmit error status set when a bus error hits the message.
// - Software sets send request; device clears it after successful send.
// - Software writing 0 to a set send request asks for an abort.
// - Setting send request clears abort, arbitration and error status.
// - Auto remote enable set: received remote request sets send request; the code does this only when bit 7 marks the buffer transmit.
// - Two-bit priority ranks 11 highest down to 00 lowest.
// - Message buffers live in DMA RAM, placed and filled by software.
// - Word 0: identifier bits 12-2, substitute remote bit 1, extended bit 0.
// - Extended flag 1 sends extended identifier, 0 standard only.
// - Substitute remote bit 1 marks a remote request message.
// - Word 1 bits 11-0 hold extended identifier bits 17 to 6.
// - Receive buffers get the filter hit code written into word 7; the code skips this write for a store onto a buffer whose full flag is set.
`default_nettype none
module cbstc_top
   import cbstc_pkg::*;
#(
   parameter int N_RX   = 32,
   parameter int N_PAIR = 8,
   parameter int N_MASK = 3
)(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // CAN core events
   input  wire cbstc_rxev_s       rx_ev,
   input  wire cbstc_rtr_s        rtr_ev,
   input  wire cbstc_txev_s       tx_ev,
   // Header words of the buffer being sent
   input  wire logic [15:0]       tx_word0,
   input  wire logic [15:0]       tx_word1,
   // Extended identifier compare
   input  wire logic [1:0]        cmp_mask_idx,
   input  wire logic [15:0]       cmp_msg_eid,
   input  wire logic [15:0]       cmp_flt_eid,
   output logic                   cmp_eid_match,
   // Transmit control to CAN core
   output logic                   tx_sel_valid,
   output logic [PIDX_W-1:0]      tx_sel_idx,
   output logic [N_PAIR-1:0]      tx_abort_req,
   output logic [N_PAIR-1:0]      buffer_is_tx,
   output cbstc_hdr_s             tx_hdr,
   // DMA word 7 write
   output cbstc_w7_s              w7_wr
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (N_RX < 1 || N_RX > 32 || N_PAIR < 2 || N_PAIR > 8 || N_PAIR % 2 != 0
       || N_MASK < 1 || N_MASK > 4 || N_PAIR > N_RX)
   begin : g_bad
      $error("cbstc_top: unsupported parameters");
   end

   // ------------------------------------------------------------
   // Bus address phase
   // ------------------------------------------------------------
   logic       dp_valid_r;
   logic       dp_write_r;
   logic [7:0] dp_addr_r;
   logic       rd_wait_r;
   logic       addr_take;
   logic       wr_now;

   assign addr_take = hsel && htrans[1] && hready;
   assign wr_now    = dp_valid_r && dp_write_r;
   // Reads take one wait state so a write just before is seen
   assign hreadyout = !rd_wait_r;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r  <= 8'h00;
      end
      else if (hready)
      begin
         dp_valid_r <= addr_take;
         dp_write_r <= hwrite;
         dp_addr_r  <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_wait_r <= 1'b0;
      else
         rd_wait_r <= addr_take && !hwrite && !rd_wait_r;
   end

   // ------------------------------------------------------------
   // Acceptance masks
   // ------------------------------------------------------------
   logic [15:0] mask_r [N_MASK];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < N_MASK; i++)
            mask_r[i] <= RST_ZERO;
      end
      else if (wr_now)
      begin
         for (int i = 0; i < N_MASK; i++)
            if (dp_addr_r == OFS_MASK_BASE + 8'(i) * OFS_STRIDE)
               mask_r[i] <= hwdata[15:0];
      end
   end

   // Only masked-in bits must agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cmp_eid_match <= 1'b0;
      else if (int'(cmp_mask_idx) < N_MASK)
         cmp_eid_match <= ((cmp_msg_eid ^ cmp_flt_eid) & mask_r[cmp_mask_idx]) == RST_ZERO;
      else
         cmp_eid_match <= 1'b0;
   end

   // ------------------------------------------------------------
   // Receive full and overflow flags
   // ------------------------------------------------------------
   logic [31:0] full_r;
   logic [31:0] ovf_r;
   logic [31:0] clr_full;
   logic [31:0] clr_ovf;
   logic [31:0] rx_hit;
   logic        rx_ok;

   assign rx_ok  = rx_ev.valid && int'(rx_ev.idx) < N_RX;
   assign rx_hit = rx_ok ? (32'h1 << rx_ev.idx) : 32'h0;

   // Zero bits of the written word clear; ones leave flags alone
   always_comb
   begin
      clr_full = 32'h0;
      clr_ovf  = 32'h0;
      if (wr_now)
      begin
         if (dp_addr_r == OFS_FULL_LO)
            clr_full[15:0] = ~hwdata[15:0];
         if (dp_addr_r == OFS_FULL_HI)
            clr_full[31:16] = ~hwdata[15:0];
         if (dp_addr_r == OFS_OVF_LO)
            clr_ovf[15:0] = ~hwdata[15:0];
         if (dp_addr_r == OFS_OVF_HI)
            clr_ovf[31:16] = ~hwdata[15:0];
      end
   end

   // A store in the clearing cycle wins over the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         full_r <= 32'h0;
      else
         full_r <= ((full_r & ~clr_full) | rx_hit) & 32'((64'h1 << N_RX) - 1);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ovf_r <= 32'h0;
      else
         ovf_r <= (ovf_r & ~clr_ovf) | (rx_hit & full_r);
   end

   // Word 7 carries the hit code; a store onto a full buffer is dropped
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         w7_wr <= '0;
      else
      begin
         w7_wr.valid <= rx_ok && !(|(rx_hit & full_r));
         w7_wr.idx   <= rx_ev.idx;
         w7_wr.data  <= 16'(rx_ev.filter_hit_code) << W7_HIT_LSB;
      end
   end

   // ------------------------------------------------------------
   // Buffer pair control
   // ------------------------------------------------------------
   cbstc_ctl_s ctl_r [N_PAIR];
   logic [N_PAIR-1:0] abort_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int b = 0; b < N_PAIR; b++)
         begin
            ctl_r[b]   <= '0;
            abort_r[b] <= 1'b0;
         end
      end
      else
      begin
         for (int b = 0; b < N_PAIR; b++)
         begin
            cbstc_ctl_s ctl_wr;
            logic sw_hit;
            logic set_req;
            logic ev_hit;
            sw_hit  = wr_now && dp_addr_r == OFS_CTL_BASE + 8'(b / 2) * OFS_STRIDE;
            ctl_wr  = cbstc_ctl_s'(hwdata[(b % 2) * 8 +: 8]);
            ev_hit  = tx_ev.valid && int'(tx_ev.idx) == b;
            set_req = (sw_hit && ctl_wr.send_request && !ctl_r[b].send_request)
                   || (rtr_ev.valid && int'(rtr_ev.idx) == b
                       && ctl_r[b].auto_remote_enable && ctl_r[b].buffer_direction);
            if (sw_hit)
            begin
               ctl_r[b].buffer_direction   <= ctl_wr.buffer_direction;
               ctl_r[b].auto_remote_enable <= ctl_wr.auto_remote_enable;
               ctl_r[b].transmit_priority  <= ctl_wr.transmit_priority;
               if (ctl_r[b].send_request && !ctl_wr.send_request)
               begin
                  ctl_r[b].send_request <= 1'b0;
                  abort_r[b]            <= 1'b1;
               end
            end
            if (ev_hit)
            begin
               unique case (tx_ev.kind)
                  CBSTC_EV_OK:
                  begin
                     ctl_r[b].send_request <= 1'b0;
                     ctl_r[b].abort_status <= 1'b0;
                     abort_r[b]            <= 1'b0;
                  end
                  CBSTC_EV_ABORT:
                  begin
                     ctl_r[b].send_request <= 1'b0;
                     ctl_r[b].abort_status <= 1'b1;
                     abort_r[b]            <= 1'b0;
                  end
                  CBSTC_EV_ARB:
                     ctl_r[b].arbitration_lost_status <= 1'b1;
                  CBSTC_EV_BUSER:
                     ctl_r[b].transmit_error_status <= 1'b1;
               endcase
            end
            // A fresh request restarts status and cancels a stale abort
            if (set_req)
            begin
               ctl_r[b].send_request            <= 1'b1;
               ctl_r[b].abort_status            <= 1'b0;
               ctl_r[b].arbitration_lost_status <= 1'b0;
               ctl_r[b].transmit_error_status   <= 1'b0;
               abort_r[b]                       <= 1'b0;
            end
         end
      end
   end

   assign tx_abort_req = abort_r;

   always_comb
   begin
      for (int b = 0; b < N_PAIR; b++)
         buffer_is_tx[b] = ctl_r[b].buffer_direction;
   end

   // ------------------------------------------------------------
   // Transmit pick
   // ------------------------------------------------------------
   logic              pick_v;
   logic [PIDX_W-1:0] pick_i;
   logic [1:0]        pick_p;

   // Strict greater-than keeps the lowest index on a tie
   always_comb
   begin
      pick_v = 1'b0;
      pick_i = '0;
      pick_p = 2'b00;
      for (int b = 0; b < N_PAIR; b++)
         if (ctl_r[b].buffer_direction && ctl_r[b].send_request
             && (!pick_v || ctl_r[b].transmit_priority > pick_p))
         begin
            pick_v = 1'b1;
            pick_i = PIDX_W'(b);
            pick_p = ctl_r[b].transmit_priority;
         end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_sel_valid <= 1'b0;
         tx_sel_idx   <= '0;
      end
      else
      begin
         tx_sel_valid <= pick_v;
         tx_sel_idx   <= pick_i;
      end
   end

   // ------------------------------------------------------------
   // Header decode of words 0 and 1 read from DMA RAM
   // ------------------------------------------------------------
   // The buffers themselves stay in DMA RAM; only headers pass here
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_hdr <= '0;
      else
      begin
         tx_hdr.sid    <= tx_word0[W0_SID_MSB:W0_SID_LSB];
         tx_hdr.remote <= tx_word0[W0_SRR];
         tx_hdr.ext    <= tx_word0[W0_IDE];
         tx_hdr.eid_hi <= tx_word0[W0_IDE] ? tx_word1[W1_EID_MSB:0] : 12'h000;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [15:0] rd_val;

   always_comb
   begin
      rd_val = RST_ZERO;
      for (int i = 0; i < N_MASK; i++)
         if (dp_addr_r == OFS_MASK_BASE + 8'(i) * OFS_STRIDE)
            rd_val = mask_r[i];
      if (dp_addr_r == OFS_FULL_LO)
         rd_val = full_r[15:0];
      if (dp_addr_r == OFS_FULL_HI)
         rd_val = full_r[31:16];
      if (dp_addr_r == OFS_OVF_LO)
         rd_val = ovf_r[15:0];
      if (dp_addr_r == OFS_OVF_HI)
         rd_val = ovf_r[31:16];
      for (int p = 0; p < N_PAIR / 2; p++)
         if (dp_addr_r == OFS_CTL_BASE + 8'(p) * OFS_STRIDE)
            rd_val = {ctl_r[2 * p + 1], ctl_r[2 * p]};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (rd_wait_r)
         hrdata <= {16'h0000, rd_val};
   end
endmodule : cbstc_top
`default_nettype wire

// ===== inc/cbstc_pkg.sv
// Constants and carriers for the CAN buffer status and transmit control block.
// Assumes a single 125 MHz clock domain and an AHB-Lite register bus.
`default_nettype none
package cbstc_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_MASK_BASE = 8'h00;
   localparam logic [7:0] OFS_FULL_LO   = 8'h0c;
   localparam logic [7:0] OFS_FULL_HI   = 8'h10;
   localparam logic [7:0] OFS_OVF_LO    = 8'h14;
   localparam logic [7:0] OFS_OVF_HI    = 8'h18;
   localparam logic [7:0] OFS_CTL_BASE  = 8'h1c;
   localparam logic [7:0] OFS_STRIDE    = 8'h04;
   localparam logic [15:0] RST_ZERO     = 16'h0000;
   // ------------------------------------------------------------
   // Message buffer word layout
   // ------------------------------------------------------------
   localparam int W0_SID_LSB = 2;
   localparam int W0_SID_MSB = 12;
   localparam int W0_SRR     = 1;
   localparam int W0_IDE     = 0;
   localparam int W1_EID_MSB = 11;
   localparam int W7_HIT_LSB = 8;
   localparam int IDX_W      = 5;
   localparam int PIDX_W     = 3;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CBSTC_EV_OK    = 2'b00,
      CBSTC_EV_ABORT = 2'b01,
      CBSTC_EV_ARB   = 2'b10,
      CBSTC_EV_BUSER = 2'b11
   } cbstc_txev_e;
   // One byte of a buffer pair control register, bit 7 first
   typedef struct packed {
      logic       buffer_direction;
      logic       abort_status;
      logic       arbitration_lost_status;
      logic       transmit_error_status;
      logic       send_request;
      logic       auto_remote_enable;
      logic [1:0] transmit_priority;
   } cbstc_ctl_s;
   typedef struct packed {
      logic              valid;
      logic [PIDX_W-1:0] idx;
      cbstc_txev_e       kind;
   } cbstc_txev_s;
   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [4:0]       filter_hit_code;
   } cbstc_rxev_s;
   typedef struct packed {
      logic              valid;
      logic [PIDX_W-1:0] idx;
   } cbstc_rtr_s;
   typedef struct packed {
      logic        ext;
      logic        remote;
      logic [10:0] sid;
      logic [11:0] eid_hi;
   } cbstc_hdr_s;
   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [15:0]      data;
   } cbstc_w7_s;
endpackage : cbstc_pkg
`default_nettype wire

// ===== sim/can_buffer_status_tx_control_tb.sv
// Self-checking bench for cbstc_top.
// Assumes hready is fed back from hreadyout.
`default_nettype none
module can_buffer_status_tx_control_tb
   import cbstc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = '0, cmp_mask_idx = '0;
   logic [15:0] cmp_msg_eid = '0, cmp_flt_eid = '0, tx_word0 = '0, tx_word1 = '0;
   cbstc_rxev_s rx_ev = '0;
   cbstc_rtr_s  rtr_ev = '0;
   cbstc_txev_s tx_ev;
   cbstc_hdr_s  tx_hdr;
   cbstc_w7_s   w7_wr;
   logic        hreadyout, hresp, cmp_eid_match, tx_sel_valid;
   logic [2:0]  tx_sel_idx;
   logic [7:0]  tx_abort_req, buffer_is_tx;
   wire         hready;
   int          err_count = 0, n_compared = 0, cyc = 0;
   assign hready = hreadyout;
   always #4 hclk = ~hclk;
   cbstc_top u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_ev(rx_ev),
      .rtr_ev(rtr_ev), .tx_ev(tx_ev), .tx_word0(tx_word0), .tx_word1(tx_word1),
      .cmp_mask_idx(cmp_mask_idx), .cmp_msg_eid(cmp_msg_eid), .cmp_flt_eid(cmp_flt_eid),
      .cmp_eid_match(cmp_eid_match), .tx_sel_valid(tx_sel_valid), .tx_sel_idx(tx_sel_idx),
      .tx_abort_req(tx_abort_req), .buffer_is_tx(buffer_is_tx), .tx_hdr(tx_hdr),
      .w7_wr(w7_wr)
   );
   cbstc_node_model u_node (.hclk(hclk), .tx_abort_req(tx_abort_req), .tx_ev(tx_ev));
   // ------------
   // Helpers
   // ------------
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   // hreadyout moves on rising edges only
   task automatic hwait(output logic [31:0] q);
      do
      begin
         @(negedge hclk);
         q = hrdata;
      end
      while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask : hwait
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hwait(q);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hwait(q);
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask : rdc
   task automatic st(input logic [7:0] e);
      rdc(OFS_CTL_BASE + OFS_STRIDE, {16'h0, e, 8'h00}, "pair control");
   endtask : st
   task automatic rtr(input logic [2:0] i);
      rtr_ev <= '{1'b1, i};
      @(posedge hclk);
      rtr_ev <= '{1'b0, ~i};
      @(posedge hclk);
   endtask : rtr
   function automatic logic [3:0] best(input cbstc_ctl_s c [8]);
      logic [3:0] r;
      r = 4'h0;
      for (int b = 7; b >= 0; b--)
         if (c[b].buffer_direction && c[b].send_request
             && (!r[3] || c[b].transmit_priority >= c[r[2:0]].transmit_priority))
            r = {1'b1, 3'(b)};
      return r;
   endfunction : best
   // ------------
   // Tests
   // ------------
   task automatic t_reset();
      for (int a = 0; a <= 'h2c; a += 4)
         rdc(8'(a), 32'h0, "reset value");
      rdc(8'h40, 32'h0, "unmapped");
      chk(hresp, 0, "okay");
      $display("test reset done");
   endtask : t_reset
   task automatic t_mask();
      logic [15:0] m, r, msg;
      for (int k = 0; k < 4; k++)
      begin
         m = 16'($urandom);
         if (k < 3)
         begin
            wr(8'(4 * k), {16'h0, m});
            rdc(8'(4 * k), {16'h0, m}, "mask readback");
         end
         for (int t = 0; t < 4; t++)
         begin
            r = (t == 0) ? 16'h0 : (t == 1) ? 16'($urandom) & ~m : (t == 2) ? m & -m
               : 16'($urandom);
            msg = 16'($urandom);
            cmp_mask_idx <= 2'(k);
            cmp_msg_eid <= msg;
            cmp_flt_eid <= msg ^ r;
            @(posedge hclk);
            @(negedge hclk);
            chk(cmp_eid_match, k < 3 && (r & m) == 0, "mask compare");
            @(posedge hclk);
         end
      end
      $display("test mask done");
   endtask : t_mask
   task automatic t_flags();
      logic [31:0] full, ovf, v;
      logic [4:0] i, h;
      logic was;
      full = 0;
      ovf = 0;
      for (int n = 0; n < 48; n++)
      begin
         i = (n == 0) ? 5'd0 : (n < 3) ? 5'd31 : 5'($urandom);
         h = 5'($urandom);
         was = full[i];
         full[i] = 1'b1;
         ovf[i] = ovf[i] | was;
         rx_ev <= '{1'b1, i, h};
         @(posedge hclk);
         rx_ev <= '{1'b0, ~i, ~h};
         @(negedge hclk);
         if (was)
            chk(w7_wr.valid, 0, "word 7 on overflow");
         else
            chk(w7_wr, {1'b1, i, 3'h0, h, 8'h00}, "word 7");
         @(posedge hclk);
      end
      for (int p = 0; p < 3; p++)
      begin
         rdc(OFS_FULL_LO, {16'h0, full[15:0]}, "full low");
         rdc(OFS_FULL_HI, {16'h0, full[31:16]}, "full high");
         rdc(OFS_OVF_LO, {16'h0, ovf[15:0]}, "ovf low");
         rdc(OFS_OVF_HI, {16'h0, ovf[31:16]}, "ovf high");
         v = (p == 0) ? 32'hffffffff : $urandom;
         wr(OFS_FULL_LO, {16'h0, v[15:0]});
         wr(OFS_FULL_HI, {16'h0, v[31:16]});
         wr(OFS_OVF_LO, {16'h0, v[15:0]});
         wr(OFS_OVF_HI, {16'h0, v[31:16]});
         full &= v;
         ovf &= v;
      end
      $display("test flags done");
   endtask : t_flags
   task automatic t_pick();
      cbstc_ctl_s c [8];
      logic [15:0] v;
      for (int n = 0; n < 8; n++)
      begin
         for (int p = 0; p < 4; p++)
         begin
            // Status bits are read-only
            v = (n == 0) ? 16'h8989 : (n == 1) ? ((p == 2) ? 16'h8b8a : 16'h0989)
               : 16'($urandom) & 16'h8f8f;
            c[2 * p] = v[7:0];
            c[2 * p + 1] = v[15:8];
            wr(OFS_CTL_BASE + 8'(4 * p), {16'h0, v});
         end
         rdc(OFS_CTL_BASE + 8'h0c, {16'h0, v}, "control readback");
         @(negedge hclk);
         chk({tx_sel_valid, tx_sel_idx}, best(c), "pick");
         chk(buffer_is_tx, {c[7][7], c[6][7], c[5][7], c[4][7], c[3][7], c[2][7], c[1][7],
             c[0][7]}, "direction");
         @(posedge hclk);
      end
      for (int p = 0; p < 4; p++)
         wr(OFS_CTL_BASE + 8'(4 * p), 32'h0);
      $display("test pick done");
   endtask : t_pick
   task automatic t_status();
      wr(8'h20, 32'h8800);
      u_node.send(3'd3, CBSTC_EV_OK, 2);
      st(8'h80);
      wr(8'h20, 32'h8800);
      wr(8'h20, 32'h8000);
      @(negedge hclk);
      chk(tx_abort_req[3], 1, "abort request");
      @(posedge hclk);
      u_node.send(3'd3, CBSTC_EV_OK, 0);
      st(8'hc0);
      wr(8'h20, 32'h8800);
      st(8'h88);
      u_node.send(3'd3, CBSTC_EV_ARB, 1);
      st(8'ha8);
      u_node.send(3'd3, CBSTC_EV_BUSER, 3);
      st(8'hb8);
      wr(8'h20, 32'h8000);
      wr(8'h20, 32'h8800);
      st(8'h88);
      u_node.send(3'd3, CBSTC_EV_OK, 1);
      wr(8'h20, 32'h8400);
      rtr(3'd3);
      st(8'h8c);
      wr(8'h20, 32'h8000);
      rtr(3'd3);
      st(8'h80);
      $display("test status done");
   endtask : t_status
   task automatic t_hdr();
      logic [15:0] w0, w1;
      for (int n = 0; n < 8; n++)
      begin
         w0 = 16'($urandom);
         w1 = 16'($urandom);
         w0[0] = n[0];
         tx_word0 <= w0;
         tx_word1 <= w1;
         @(posedge hclk);
         @(negedge hclk);
         chk(tx_hdr, {w0[0], w0[1], w0[12:2], w0[0] ? w1[11:0] : 12'h0},
             "header");
         @(posedge hclk);
      end
      $display("test header done");
   endtask : t_hdr
   initial
   begin
      void'($urandom(82));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_mask();
      t_flags();
      t_pick();
      t_status();
      t_hdr();
      end_of_test();
   end
endmodule : can_buffer_status_tx_control_tb
`default_nettype wire

// ===== sim/cbstc_asserts.sv
// Port checker for cbstc_top.
// Assumes hready is fed back from hreadyout.
`default_nettype none
module cbstc_asserts
   import cbstc_pkg::*;
#(
   parameter int N_PAIR = 8
)(
   // Clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // Bus
   input wire logic              hsel,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic              hreadyout,
   // Events and header words
   input wire cbstc_rxev_s       rx_ev,
   input wire cbstc_txev_s       tx_ev,
   input wire logic [15:0]       tx_word0,
   input wire logic [15:0]       tx_word1,
   // Identifier compare
   input wire logic [1:0]        cmp_mask_idx,
   input wire logic [15:0]       cmp_msg_eid,
   input wire logic [15:0]       cmp_flt_eid,
   input wire logic              cmp_eid_match,
   // Transmit side
   input wire logic              tx_sel_valid,
   input wire logic [PIDX_W-1:0] tx_sel_idx,
   input wire logic [N_PAIR-1:0] tx_abort_req,
   input wire logic [N_PAIR-1:0] buffer_is_tx,
   input wire cbstc_hdr_s        tx_hdr,
   input wire cbstc_w7_s         w7_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ------------
   // Properties
   // ------------
   sequence s_rd_take;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rd_wait;
      s_rd_take |=> s_rd_wait;
   endproperty
   property p_w7;
      w7_wr.valid |-> $past(rx_ev.valid) && w7_wr.idx == $past(rx_ev.idx)
         && w7_wr.data == {3'h0, $past(rx_ev.filter_hit_code), 8'h00};
   endproperty
   // Skips the release edge
   property p_hdr_id;
      $past(hresetn) |-> tx_hdr.sid == $past(tx_word0[12:2])
         && tx_hdr.remote == $past(tx_word0[1]);
   endproperty
   property p_hdr_ext;
      $past(hresetn) |-> tx_hdr.ext == $past(tx_word0[0])
         && tx_hdr.eid_hi == ($past(tx_word0[0]) ? $past(tx_word1[11:0]) : 12'h000);
   endproperty
   property p_cmp_eq;
      cmp_mask_idx != 2'h3 && cmp_msg_eid == cmp_flt_eid |=> cmp_eid_match;
   endproperty
   property p_cmp_off;
      cmp_mask_idx == 2'h3 |=> !cmp_eid_match;
   endproperty
   property p_sel_dir;
      tx_sel_valid |-> (($past(buffer_is_tx) >> tx_sel_idx) & 1) != 0;
   endproperty
   property p_abort_clr;
      tx_ev.valid && (tx_ev.kind == CBSTC_EV_OK || tx_ev.kind == CBSTC_EV_ABORT)
         |=> !tx_abort_req[$past(tx_ev.idx)];
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait");
   a_w7: assert property (p_w7) else $error("word 7");
   a_hdr_id: assert property (p_hdr_id) else $error("header id");
   a_hdr_ext: assert property (p_hdr_ext) else $error("header ext");
   a_cmp_eq: assert property (p_cmp_eq) else $error("id match");
   a_cmp_off: assert property (p_cmp_off) else $error("bad mask");
   a_sel_dir: assert property (p_sel_dir) else $error("pick dir");
   a_abort_clr: assert property (p_abort_clr) else $error("abort kept");
endmodule : cbstc_asserts
bind cbstc_top cbstc_asserts #(.N_PAIR(N_PAIR)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .rx_ev(rx_ev), .tx_ev(tx_ev),
   .tx_word0(tx_word0), .tx_word1(tx_word1), .cmp_mask_idx(cmp_mask_idx),
   .cmp_msg_eid(cmp_msg_eid), .cmp_flt_eid(cmp_flt_eid), .cmp_eid_match(cmp_eid_match),
   .tx_sel_valid(tx_sel_valid), .tx_sel_idx(tx_sel_idx), .tx_abort_req(tx_abort_req),
   .buffer_is_tx(buffer_is_tx), .tx_hdr(tx_hdr), .w7_wr(w7_wr)
);
`default_nettype wire

// ===== sim/cbstc_node_model.sv
// Far side: CAN core reporting transmit outcomes.
// Assumes the bench calls send right after a rising edge.
`default_nettype none
module cbstc_node_model
   import cbstc_pkg::*;
(
   // Clock
   input  wire logic       hclk,
   // Abort requests from the block
   input  wire logic [7:0] tx_abort_req,
   // Transmit outcome
   output var cbstc_txev_s tx_ev
);
   timeunit 1ns;
   timeprecision 1ps;
   initial tx_ev = '0;
   // A pending abort wins over the asked outcome
   task automatic send(input logic [2:0] i, input cbstc_txev_e k, input int d);
      repeat (d) @(posedge hclk);
      tx_ev <= '{1'b1, i, tx_abort_req[i] ? CBSTC_EV_ABORT : k};
      @(posedge hclk);
      tx_ev <= '{1'b0, ~i, k};
   endtask : send
endmodule : cbstc_node_model
`default_nettype wire
